// *** hw/cid_regs.svh ***
`ifndef CID_REGS_SVH
`define CID_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CID_OFF_CTRL 8'h00
`define CID_OFF_INSTR 8'h04
`define CID_OFF_STATUS 8'h08
`define CID_OFF_ACC 8'h0C
`define CID_OFF_PC 8'h10
`define CID_OFF_STACK 8'h14
`define CID_OFF_WDT 8'h18
`define CID_OFF_STATE 8'h1C
`define CID_OFF_COUNT 8'h20
`define CID_OFF_RESULT 8'h24
`define CID_FILE_SEL_BIT 7

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CID_CTRL_PSA_BIT 0
`define CID_INSTR_OP_LSB 0
`define CID_INSTR_DEST_BIT 4
`define CID_INSTR_FADR_LSB 8
`define CID_INSTR_LIT_LSB 16
`define CID_ST_NULL_BIT 2
`define CID_ST_SLEEP_BIT 3
`define CID_ST_EXPIRY_BIT 4
`define CID_ST_PAGE_LSB 5
`define CID_STATE_BUSY_BIT 0
`define CID_STATE_SECOND_BIT 1
`define CID_STATE_ILLEGAL_BIT 2
`define CID_WDT_PRESC_LSB 8

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define CID_STATUS_RST 8'h18
`define CID_CTRL_RST 1'b1
`define CID_CYC_CLKS 4

`endif

// *** hw/cid_pkg.sv ***
package cid_pkg;

  typedef enum logic [3:0] {
    CID_OP_NOP,
    CID_OP_CALL,
    CID_OP_ACC_CLR,
    CID_OP_WDT_KICK,
    CID_OP_FILE_CLR,
    CID_OP_INV,
    CID_OP_DEC,
    CID_OP_INC
  } cid_op_t;

  typedef enum logic [1:0] {
    CID_ENG_IDLE,
    CID_ENG_FIRST,
    CID_ENG_SECOND
  } cid_eng_t;

endpackage

// *** hw/cid_file_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module cid_file_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic we,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("cid_file_mem: unsupported parameters");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage, read data registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

`default_nettype wire

// *** hw/cid_core_slice.sv ***
// Functional notes
// - Call pushes PC plus one first
// - Call literal loads PC low byte
// - Call copies page bits, clears PC bit8
// - Call takes two cycles, flags unchanged
// - Accumulator clear writes zero, sets null
// - Watchdog kick zeroes watchdog counter
// - Kick clears prescaler only if watchdog-assigned
// - Kick sets expiry and sleep flags only
// - File clear zeroes register, sets null
// - Invert complements file, dest steers, null
// - Decrement file, dest steers, null updated
// - Increment file, dest steers, null updated
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cid_regs.svh"

module cid_core_slice #(
  parameter int CYC_CLKS = `CID_CYC_CLKS,
  parameter int STACK_DEPTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic busy,
  output cid_pkg::cid_op_t exec_op,
  output logic wdt_clear_pulse,
  output logic presc_clear_pulse
);
  import cid_pkg::*;

  if (CYC_CLKS < 2 || CYC_CLKS > 256 || STACK_DEPTH < 1) begin : g_bad
    $error("cid_core_slice: unsupported parameters");
  end

  localparam int CW = (CYC_CLKS > 2) ? $clog2(CYC_CLKS) : 1;
  localparam logic [CW-1:0] CNT_LAST = CW'(CYC_CLKS - 1);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cid_eng_t st_r;
  logic [CW-1:0] cnt_r;
  logic [31:0] instr_r;
  cid_op_t op_r;
  logic dest_r;
  logic [4:0] fadr_r;
  logic [7:0] lit_r;
  logic [7:0] acc_r;
  logic [7:0] status_r;
  logic [10:0] pc_r;
  logic [10:0] stack_r [STACK_DEPTH];
  logic psa_r;
  logic [7:0] wdt_cnt_r;
  logic [7:0] presc_r;
  logic illegal_r;
  logic [15:0] exec_cnt_r;
  logic [7:0] result_r;
  logic ack_r;
  logic frd_pend_r;

  logic req;
  logic is_file;
  logic bus_ok;
  logic wr_go;
  logic [31:0] wmerge;
  logic [31:0] rd_mux;
  logic start;
  logic last_clk;
  logic push_now;
  logic exec_now;
  logic [7:0] mem_rdata;
  logic [4:0] mem_addr;
  logic mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] res;
  logic res_acc;
  logic res_file;
  logic null_upd;
  logic kick;
  logic [31:0] acc_wmerge;
  logic [31:0] pc_wmerge;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign req = avs_read | avs_write;
  assign is_file = avs_address[`CID_FILE_SEL_BIT];
  assign wr_go = avs_write & ack_r;
  assign avs_waitrequest = req & ~ack_r;

  // The file bank has one port, so the bus waits while an instruction owns it
  always_comb begin
    bus_ok = 1'b1;
    if (is_file && busy) begin
      bus_ok = 1'b0;
    end
    if (avs_write && avs_address == `CID_OFF_INSTR && busy) begin
      bus_ok = 1'b0;
    end
    if (avs_read && is_file && !frd_pend_r) begin
      bus_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      frd_pend_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r & bus_ok;
      frd_pend_r <= avs_read & is_file & ~busy & ~ack_r & ~frd_pend_r;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (is_file) begin
      rd_mux = {24'h00_0000, mem_rdata};
    end else begin
      case (avs_address)
        `CID_OFF_CTRL: rd_mux[`CID_CTRL_PSA_BIT] = psa_r;
        `CID_OFF_INSTR: rd_mux = instr_r;
        `CID_OFF_STATUS: rd_mux = {24'h00_0000, status_r};
        `CID_OFF_ACC: rd_mux = {24'h00_0000, acc_r};
        `CID_OFF_PC: rd_mux = {21'h00_0000, pc_r};
        `CID_OFF_STACK: rd_mux = {21'h00_0000, stack_r[0]};
        `CID_OFF_WDT: rd_mux = {16'h0000, presc_r, wdt_cnt_r};
        `CID_OFF_STATE: begin
          rd_mux[`CID_STATE_BUSY_BIT] = busy;
          rd_mux[`CID_STATE_SECOND_BIT] = (st_r == CID_ENG_SECOND);
          rd_mux[`CID_STATE_ILLEGAL_BIT] = illegal_r;
        end
        `CID_OFF_COUNT: rd_mux = {16'h0000, exec_cnt_r};
        `CID_OFF_RESULT: rd_mux = {24'h00_0000, result_r};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r && bus_ok) begin
      avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Instruction latch and sequencer
  // ----------------------------------------------------------------
  assign wmerge = be_merge(instr_r, avs_writedata, avs_byteenable);
  assign acc_wmerge = be_merge({24'h00_0000, acc_r}, avs_writedata, avs_byteenable);
  assign pc_wmerge = be_merge({21'h00_0000, pc_r}, avs_writedata, avs_byteenable);
  assign start = wr_go && !is_file && avs_address == `CID_OFF_INSTR;
  assign busy = (st_r != CID_ENG_IDLE);
  assign exec_op = op_r;
  assign last_clk = busy && cnt_r == CNT_LAST;
  assign push_now = last_clk && st_r == CID_ENG_FIRST && op_r == CID_OP_CALL;
  assign exec_now = last_clk && (st_r == CID_ENG_SECOND || op_r != CID_OP_CALL);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      instr_r <= 32'h0000_0000;
      op_r <= CID_OP_NOP;
      dest_r <= 1'b0;
      fadr_r <= 5'h00;
      lit_r <= 8'h00;
    end else if (start) begin
      instr_r <= wmerge;
      // Codes past the last operation run as a no-op and raise a sticky flag
      op_r <= wmerge[`CID_INSTR_OP_LSB + 3] ? CID_OP_NOP : cid_op_t'(wmerge[`CID_INSTR_OP_LSB +: 4]);
      dest_r <= wmerge[`CID_INSTR_DEST_BIT];
      fadr_r <= wmerge[`CID_INSTR_FADR_LSB +: 5];
      lit_r <= wmerge[`CID_INSTR_LIT_LSB +: 8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= CID_ENG_IDLE;
      cnt_r <= '0;
    end else begin
      case (st_r)
        CID_ENG_IDLE: begin
          cnt_r <= '0;
          if (start) begin
            st_r <= CID_ENG_FIRST;
          end
        end
        CID_ENG_FIRST: begin
          if (cnt_r == CNT_LAST) begin
            cnt_r <= '0;
            st_r <= (op_r == CID_OP_CALL) ? CID_ENG_SECOND : CID_ENG_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        CID_ENG_SECOND: begin
          if (cnt_r == CNT_LAST) begin
            cnt_r <= '0;
            st_r <= CID_ENG_IDLE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          st_r <= CID_ENG_IDLE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // File bank and result path
  // ----------------------------------------------------------------
  assign mem_addr = busy ? fadr_r : avs_address[6:2];
  assign mem_we = (exec_now & res_file) | (wr_go & is_file & avs_byteenable[0]);
  assign mem_wdata = busy ? res : avs_writedata[7:0];

  cid_file_mem #(
    .DEPTH(32),
    .WIDTH(8)
  ) u_file (
    .sys_clk(sys_clk),
    .addr(mem_addr),
    .we(mem_we),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // File data is valid from the second clock of the cycle; results are used only at the last
  always_comb begin
    res = 8'h00;
    res_acc = 1'b0;
    res_file = 1'b0;
    null_upd = 1'b0;
    kick = 1'b0;
    case (op_r)
      CID_OP_ACC_CLR: begin
        res_acc = 1'b1;
        null_upd = 1'b1;
      end
      CID_OP_FILE_CLR: begin
        res_file = 1'b1;
        null_upd = 1'b1;
      end
      CID_OP_INV: begin
        res = ~mem_rdata;
        res_acc = ~dest_r;
        res_file = dest_r;
        null_upd = 1'b1;
      end
      CID_OP_DEC: begin
        res = mem_rdata - 8'h01;
        res_acc = ~dest_r;
        res_file = dest_r;
        null_upd = 1'b1;
      end
      CID_OP_INC: begin
        res = mem_rdata + 8'h01;
        res_acc = ~dest_r;
        res_file = dest_r;
        null_upd = 1'b1;
      end
      CID_OP_WDT_KICK: kick = 1'b1;
      default: res = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_r <= 8'h00;
    end else if (exec_now && res_acc) begin
      acc_r <= res;
    end else if (wr_go && !is_file && avs_address == `CID_OFF_ACC) begin
      acc_r <= acc_wmerge[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_r <= 8'h00;
      exec_cnt_r <= 16'h0000;
    end else if (exec_now) begin
      result_r <= res;
      exec_cnt_r <= exec_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Status register
  // ----------------------------------------------------------------
  // Hardware updates land after a software write in the same clock, so they win
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= `CID_STATUS_RST;
    end else begin
      if (wr_go && !is_file && avs_address == `CID_OFF_STATUS && avs_byteenable[0]) begin
        status_r <= avs_writedata[7:0];
      end
      if (exec_now && null_upd) begin
        status_r[`CID_ST_NULL_BIT] <= (res == 8'h00);
      end
      if (exec_now && kick) begin
        status_r[`CID_ST_EXPIRY_BIT] <= 1'b1;
        status_r[`CID_ST_SLEEP_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      illegal_r <= 1'b0;
    end else if (start && wmerge[`CID_INSTR_OP_LSB + 3]) begin
      illegal_r <= 1'b1;
    end else if (wr_go && !is_file && avs_address == `CID_OFF_STATE &&
                 avs_writedata[`CID_STATE_ILLEGAL_BIT]) begin
      illegal_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= 11'h000;
    end else if (exec_now && op_r == CID_OP_CALL) begin
      pc_r <= {status_r[`CID_ST_PAGE_LSB +: 2], 1'b0, lit_r};
    end else if (exec_now) begin
      pc_r <= pc_r + 11'h001;
    end else if (wr_go && !is_file && avs_address == `CID_OFF_PC) begin
      pc_r <= pc_wmerge[10:0];
    end
  end

  // Deepest entry falls off when the stack overflows
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= 11'h000;
      end
    end else if (push_now) begin
      stack_r[0] <= pc_r + 11'h001;
      for (int i = 1; i < STACK_DEPTH; i++) begin
        stack_r[i] <= stack_r[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog and shared prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      psa_r <= `CID_CTRL_RST;
    end else if (wr_go && !is_file && avs_address == `CID_OFF_CTRL && avs_byteenable[0]) begin
      psa_r <= avs_writedata[`CID_CTRL_PSA_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      presc_r <= 8'h00;
    end else if (exec_now && kick && psa_r) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  // Counter ticks on prescaler wrap when assigned, else every clock
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_cnt_r <= 8'h00;
    end else if (exec_now && kick) begin
      wdt_cnt_r <= 8'h00;
    end else if (!psa_r || presc_r == 8'hFF) begin
      wdt_cnt_r <= wdt_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_clear_pulse <= 1'b0;
      presc_clear_pulse <= 1'b0;
    end else begin
      wdt_clear_pulse <= exec_now & kick;
      presc_clear_pulse <= exec_now & kick & psa_r;
    end
  end

endmodule

`default_nettype wire

// *** testbench/cid_core_slice_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module cid_core_slice_props #(
  parameter int CYC_CLKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic busy,
  input wire cid_pkg::cid_op_t exec_op,
  input wire logic wdt_clear_pulse,
  input wire logic presc_clear_pulse
);
  import cid_pkg::*;
  logic [7:0] busy_cnt_r;
  logic ctrl_r;
  // Shadow of the prescaler owner, since the checker cannot see the register itself
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_r <= 8'h00;
      ctrl_r <= 1'b1;
    end else begin
      busy_cnt_r <= busy ? busy_cnt_r + 8'h01 : 8'h00;
      if (avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0]) begin
        ctrl_r <= avs_writedata[0];
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_busy_length: assert property (
    $fell(busy) |-> int'(busy_cnt_r) == ((exec_op == CID_OP_CALL) ? 2 * CYC_CLKS : CYC_CLKS))
    else $error("busy length wrong for this op");
  a_op_hold: assert property (
    busy && $past(busy) |-> $stable(exec_op)) else $error("op changed mid execution");
  a_kick_pulse: assert property (
    $fell(busy) && exec_op == CID_OP_WDT_KICK |-> wdt_clear_pulse) else $error("kick gave no clear pulse");
  a_pulse_cause: assert property (
    $rose(wdt_clear_pulse) |-> exec_op == CID_OP_WDT_KICK && $past(busy, 2))
    else $error("clear pulse without kick");
  a_pulse_once: assert property (
    wdt_clear_pulse |=> !wdt_clear_pulse) else $error("clear pulse too long");
  a_presc_owner: assert property (
    wdt_clear_pulse |-> presc_clear_pulse == ctrl_r) else $error("prescaler clear ignores owner");
  a_presc_only: assert property (
    presc_clear_pulse |-> wdt_clear_pulse) else $error("prescaler cleared alone");
  a_instr_stall: assert property (
    avs_write && avs_address == 8'h04 && busy |-> avs_waitrequest) else $error("instruction taken while busy");
  a_wait_idle: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest) else $error("waitrequest without request");
  c_call: cover property ($fell(busy) && exec_op == CID_OP_CALL);
  c_kick: cover property (wdt_clear_pulse);
  c_presc: cover property (presc_clear_pulse);
endmodule
bind cid_core_slice cid_core_slice_props #(.CYC_CLKS(CYC_CLKS)) u_props (
  .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .exec_op(exec_op),
  .wdt_clear_pulse(wdt_clear_pulse), .presc_clear_pulse(presc_clear_pulse)
);
`default_nettype wire

// *** testbench/cid_core_slice_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cid_regs.svh"
module cid_core_slice_bench;
  import cid_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic busy;
  cid_op_t exec_op;
  logic wdt_clear_pulse;
  logic presc_clear_pulse;
  logic [31:0] rd;
  int miscompares = 0;
  int n_tests = 0;
  int wdt_seen = 0;
  int presc_seen = 0;
  always #5 sys_clk = ~sys_clk;
  cid_core_slice #(.CYC_CLKS(4), .STACK_DEPTH(2)) DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .exec_op(exec_op),
    .wdt_clear_pulse(wdt_clear_pulse), .presc_clear_pulse(presc_clear_pulse)
  );
  always @(posedge sys_clk) begin
    if (wdt_clear_pulse === 1'b1) wdt_seen++;
    if (presc_clear_pulse === 1'b1) presc_seen++;
  end
  // ----------------------------------------
  // Bus and check helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  // Request held until waitrequest is seen low; the bound only guards a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 200);
    if (n >= 200) miscompares++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
  endtask
  task automatic issue(input cid_op_t op, input logic d, input logic [4:0] f, input logic [7:0] k);
    bus(1'b1, `CID_OFF_INSTR, {8'h00, k, 3'b000, f, 3'b000, d, op});
    wait_idle();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_file_ops();
    cid_op_t ops [7] = '{CID_OP_INV, CID_OP_INV, CID_OP_DEC, CID_OP_DEC, CID_OP_INC, CID_OP_INC, CID_OP_FILE_CLR};
    logic [7:0] vals [7] = '{8'h00, 8'hff, 8'h01, 8'h00, 8'h7f, 8'hff, 8'ha5};
    logic [7:0] res;
    logic d;
    logic [4:0] f;
    for (int i = 0; i < 7; i++) begin
      d = i[0] | (i == 6);
      f = (i == 6) ? 5'h1f : 5'(i * 5);
      case (ops[i])
        CID_OP_INV: res = ~vals[i];
        CID_OP_DEC: res = vals[i] - 8'h01;
        CID_OP_INC: res = vals[i] + 8'h01;
        default: res = 8'h00;
      endcase
      bus(1'b1, {1'b1, f, 2'b00}, {24'h0, vals[i]});
      bus(1'b1, `CID_OFF_ACC, 32'h0000_005a);
      issue(ops[i], d, f, 8'h00);
      bus(1'b0, `CID_OFF_ACC, 32'h0);
      chk(rd, {24'h0, d ? 8'h5a : res});
      bus(1'b0, {1'b1, f, 2'b00}, 32'h0);
      chk(rd, {24'h0, d ? res : vals[i]});
      bus(1'b0, `CID_OFF_STATUS, 32'h0);
      chk(32'(rd[2]), 32'(res == 8'h00));
    end
  endtask
  task automatic t_acc_clr();
    bus(1'b1, `CID_OFF_ACC, 32'h0000_0033);
    bus(1'b1, `CID_OFF_STATUS, 32'h0000_0000);
    issue(CID_OP_ACC_CLR, 1'b0, 5'h00, 8'h00);
    bus(1'b0, `CID_OFF_ACC, 32'h0);
    chk(rd, 32'h0000_0000);
    bus(1'b0, `CID_OFF_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h1);
  endtask
  // First pass gives the prescaler to the watchdog, second to the first counter
  task automatic t_kick();
    int w0;
    int p0;
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, `CID_OFF_CTRL, 32'(i == 0));
      bus(1'b1, `CID_OFF_STATUS, 32'h0000_0004);
      w0 = wdt_seen;
      p0 = presc_seen;
      issue(CID_OP_WDT_KICK, 1'b0, 5'h00, 8'h00);
      repeat (2) @(posedge sys_clk);
      chk(32'(wdt_seen - w0), 32'h1);
      chk(32'(presc_seen - p0), 32'(i == 0));
      bus(1'b0, `CID_OFF_STATUS, 32'h0);
      chk({29'h0, rd[6:5], rd[2]}, 32'h1);
      chk(32'(rd[4:3]), 32'h3);
      bus(1'b0, `CID_OFF_WDT, 32'h0);
      if (i == 0) chk(32'(rd[7:0] == 8'h00 && rd[15:8] < 8'h20), 32'h1);
    end
  endtask
  task automatic t_call();
    logic [1:0] pg [2] = '{2'b11, 2'b01};
    logic [7:0] lit [2] = '{8'hab, 8'h00};
    logic [10:0] pc;
    logic [31:0] st;
    bus(1'b1, `CID_OFF_PC, 32'h0000_0123);
    for (int i = 0; i < 2; i++) begin
      bus(1'b0, `CID_OFF_PC, 32'h0);
      pc = rd[10:0];
      bus(1'b1, `CID_OFF_STATUS, {25'h0, pg[i], 5'h04});
      bus(1'b0, `CID_OFF_STATUS, 32'h0);
      st = rd;
      issue(CID_OP_CALL, 1'b0, 5'h00, lit[i]);
      bus(1'b0, `CID_OFF_STACK, 32'h0);
      chk(rd, {21'h0, pc + 11'h001});
      bus(1'b0, `CID_OFF_PC, 32'h0);
      chk(rd, {21'h0, pg[i], 1'b0, lit[i]});
      bus(1'b0, `CID_OFF_STATUS, 32'h0);
      chk(rd, st);
    end
  endtask
  // Second instruction is offered while the first still runs and must wait
  task automatic t_stall();
    bus(1'b1, 8'h88, 32'h0000_0010);
    bus(1'b1, `CID_OFF_INSTR, {8'h00, 8'h00, 3'b000, 5'h02, 3'b000, 1'b1, CID_OP_INC});
    issue(CID_OP_INC, 1'b1, 5'h02, 8'h00);
    bus(1'b0, 8'h88, 32'h0);
    chk(rd, 32'h0000_0012);
    bus(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0000_0000);
    // Codes past the last operation run as a no-op and raise the sticky flag
    bus(1'b1, `CID_OFF_INSTR, 32'h0000_0008);
    wait_idle();
    bus(1'b0, `CID_OFF_STATE, 32'h0);
    chk(rd, 32'h0000_0004);
    bus(1'b1, `CID_OFF_STATE, 32'h0000_0004);
    bus(1'b0, `CID_OFF_STATE, 32'h0);
    chk(rd, 32'h0000_0000);
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(1'b0, `CID_OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_0018);
    t_file_ops();
    t_acc_clr();
    t_kick();
    t_call();
    t_stall();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
